// ### hw/llacs_addr_dec.sv
// Address field decoder
`timescale 1ns/10ps
`default_nettype none
module llacs_addr_dec
  import llacs_pkg::*;
(
  llacs_dec_if.adr d
);
  // Octet 1 bit 1 is 0, octet 2 bit 1 is 1
  assign d.ea_ok    = !d.rxh[0] && d.rxh[8];
  assign d.is_cmd   = d.rxh[1] ^ d.net;
  assign d.sap      = d.rxh[7:2];
  assign d.endpoint_id      = d.rxh[15:9];
  assign d.group    = d.rxh[15:9] == LLACS_TEI_GRP;
  assign d.auto_rng = d.rxh[15:9] >= LLACS_TEI_AUTO && !d.group;
endmodule : llacs_addr_dec
`default_nettype wire

// ### hw/llacs_ctl_dec.sv
// Control field decoder
`timescale 1ns/10ps
`default_nettype none
module llacs_ctl_dec
  import llacs_pkg::*;
(
  llacs_dec_if.ctl d
);
  logic [7:0] c1;

  assign c1 = d.rxh[23:16];

  always_comb begin
    d.ns    = c1[7:1];
    d.nr    = d.rxh[31:25];
    d.pf    = d.rxh[24];
    d.ucode = LLACS_U_NONE;
    d.undef = 1'b0;
    if (!c1[0]) begin
      d.fmt = LLACS_F_I;
    end else if (!c1[1]) begin
      d.fmt   = LLACS_F_S;
      d.undef = c1[7:4] != 4'h0 || c1[3:2] == 2'h3;
    end else begin
      d.fmt = LLACS_F_U;
      d.pf  = c1[4];
      for (int i = 0; i < 7; i++) begin
        if ((c1 & 8'hef) == LLACS_U_ENC[i]) begin
          d.ucode = 3'(i);
        end
      end
      d.undef = d.ucode == LLACS_U_NONE;
    end
  end
endmodule : llacs_ctl_dec
`default_nettype wire

// ### hw/llacs_dec_if.sv
// Interface: received header and its decoded fields
`timescale 1ns/10ps
`default_nettype none
interface llacs_dec_if;
  logic [31:0] rxh;
  logic        net;
  logic        ea_ok;
  logic        is_cmd;
  logic [5:0]  sap;
  logic [6:0]  endpoint_id;
  logic        group;
  logic        auto_rng;
  logic [1:0]  fmt;
  logic        pf;
  logic [6:0]  ns;
  logic [6:0]  nr;
  logic [2:0]  ucode;
  logic        undef;
  modport adr (input rxh, net, output ea_ok, is_cmd, sap, endpoint_id, group, auto_rng);
  modport ctl (input rxh, output fmt, pf, ns, nr, ucode, undef);
  modport top (output rxh, net, input ea_ok, is_cmd, sap, endpoint_id, group, auto_rng,
               fmt, pf, ns, nr, ucode, undef);
endinterface : llacs_dec_if
`default_nettype wire

// ### hw/llacs_pkg.sv
// Package: constants and types of the link layer address and control block
package llacs_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] LLACS_A_CFG  = 8'h00;
  localparam logic [7:0] LLACS_A_RXH  = 8'h04;
  localparam logic [7:0] LLACS_A_RXS  = 8'h08;
  localparam logic [7:0] LLACS_A_TXC  = 8'h0c;
  localparam logic [7:0] LLACS_A_TXH  = 8'h10;
  localparam logic [7:0] LLACS_A_VAR  = 8'h14;
  localparam logic [7:0] LLACS_A_MAX_INFO_OCTETS = 8'h18;

  // ----------------------------------------
  // Reset values and address constants
  // ----------------------------------------
  localparam logic [6:0]  LLACS_K_RST    = 7'h07;
  localparam logic [15:0] LLACS_MAX_INFO_OCTETS_RST = 16'h0100;
  localparam logic [6:0]  LLACS_TEI_GRP  = 7'h7f;
  localparam logic [6:0]  LLACS_TEI_AUTO = 7'h40;

  // ----------------------------------------
  // Frame formats and encodings, P/F bit clear
  // ----------------------------------------
  localparam logic [1:0] LLACS_F_I = 2'h0;
  localparam logic [1:0] LLACS_F_S = 2'h1;
  localparam logic [1:0] LLACS_F_U = 2'h3;
  localparam logic [2:0] LLACS_U_SET_EXTENDED_BALANCED_MODE = 3'h1;
  localparam logic [2:0] LLACS_U_UA    = 3'h4;
  localparam logic [2:0] LLACS_U_NONE  = 3'h7;
  // Index 0 UI, 1 SET_EXTENDED_BALANCED_MODE, 2 DISC, 3 DM, 4 UA, 5 FRMR, 6 XID
  localparam logic [6:0][7:0] LLACS_U_ENC =
    {8'haf, 8'h87, 8'h63, 8'h0f, 8'h43, 8'h6f, 8'h03};

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [8:0] rsv1;
    logic [6:0] k;
    logic       rsv0;
    logic       unack;
    logic       net;
    logic [6:0] endpoint_id;
    logic [5:0] sap;
  } llacs_cfg_s;

  typedef struct packed {
    logic [2:0] rsv;
    logic       poll;
    logic       set_extended_balanced_mode;
    logic [2:0] ucode;
    logic       undef;
    logic       seq_ok;
    logic       nr_err;
    logic       auto_rng;
    logic       group;
    logic       addr_ok;
    logic [6:0] nr;
    logic [6:0] ns;
    logic       pf;
    logic       is_cmd;
    logic [1:0] fmt;
  } llacs_rxs_s;

  typedef enum logic [2:0] {
    LLACS_ST_IDLE = 3'b001,
    LLACS_ST_RX   = 3'b010,
    LLACS_ST_TX   = 3'b100
  } llacs_st_e;

endpackage : llacs_pkg

// ### hw/llacs_top.sv
// Link layer address, control and sequence logic with a Wishbone slave
`timescale 1ns/10ps
`default_nettype none
module llacs_top
  import llacs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    llacs_st_e   st;
    logic        ack;
    logic [31:0] dat;
    llacs_cfg_s  cfg;
    logic [15:0] max_info_octets;
    logic [31:0] rxh;
    llacs_rxs_s  rxs;
    logic [6:0]  txc;
    logic [31:0] txh;
    logic [6:0]  vs;
    logic [6:0]  va;
    logic [6:0]  vr;
    logic        poll;
    logic        refused;
    logic        ua_due;
  } llacs_top_s;

  llacs_top_s r;
  llacs_top_s n;

  llacs_dec_if d ();

  logic        req;
  logic [31:0] wm;
  logic [31:0] rd;
  logic [6:0]  d_nr;
  logic [6:0]  d_vs;
  logic [6:0]  out_cnt;
  logic        nr_ok;
  logic        win_full;
  logic        addr_ok;
  logic        rx_live;
  logic [1:0]  tfmt;
  logic [2:0]  tcode;
  logic        tresp;
  logic        tf;
  logic [7:0]  oa1;
  logic [7:0]  oa2;
  logic [7:0]  ouc;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  assign d.rxh = r.rxh;
  assign d.net = r.cfg.net;

  llacs_addr_dec u_adr (
    .d (d.adr)
  );

  llacs_ctl_dec u_ctl (
    .d (d.ctl)
  );

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  assign req = wb_cyc_i && wb_stb_i && !r.ack;
  assign wm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Modulo distances avoid any wrap special case
  assign d_nr     = 7'(d.nr - r.va);
  assign d_vs     = 7'(r.vs - r.va);
  assign nr_ok    = d_nr <= d_vs;
  assign out_cnt  = 7'(r.vs - r.va);
  assign win_full = out_cnt >= r.cfg.k;

  assign addr_ok = d.ea_ok && d.sap == r.cfg.sap &&
                   (d.endpoint_id == r.cfg.endpoint_id || d.group);
  assign rx_live = r.st == LLACS_ST_RX && addr_ok && !r.cfg.unack;

  assign tfmt  = r.txc[1:0];
  assign tcode = r.txc[4:2];
  assign tresp = r.txc[6];
  // A response answers a pending poll with F set, otherwise F stays clear; a command takes P from TXC bit 5
  assign tf    = tresp ? r.poll : r.txc[5];
  assign oa1   = {r.cfg.sap, tresp ^ r.cfg.net, 1'b0};
  assign oa2   = {r.cfg.endpoint_id, 1'b1};
  assign ouc   = LLACS_U_ENC[tcode] | {3'h0, tf, 4'h0};

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    case (wb_adr_i)
      LLACS_A_CFG:  rd = r.cfg;
      LLACS_A_RXH:  rd = r.rxh;
      LLACS_A_RXS:  rd = r.rxs;
      LLACS_A_TXC:  rd = {25'h000_0000, r.txc};
      LLACS_A_TXH:  rd = r.txh;
      LLACS_A_VAR:  rd = {5'h00, r.ua_due, r.refused, win_full,
                          1'b0, r.vr, 1'b0, r.va, 1'b0, r.vs};
      LLACS_A_MAX_INFO_OCTETS: rd = {16'h0000, r.max_info_octets};
      default:      rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n     = r;
    n.ack = req;
    n.st  = LLACS_ST_IDLE;
    if (req) begin
      n.dat = wb_we_i ? 32'h0000_0000 : rd;
    end

    // Register writes
    if (req && wb_we_i) begin
      case (wb_adr_i)
        LLACS_A_CFG: begin
          n.cfg = (r.cfg & ~wm) | (wb_dat_i & wm);
          // Window of zero would stall forever
          if (n.cfg.k == 7'h00) begin
            n.cfg.k = 7'h01;
          end
          n.cfg.rsv0 = 1'b0;
          n.cfg.rsv1 = 9'h000;
        end
        LLACS_A_RXH: begin
          n.rxh = (r.rxh & ~wm) | (wb_dat_i & wm);
          n.st  = LLACS_ST_RX;
        end
        LLACS_A_TXC: begin
          n.txc = wb_dat_i[6:0];
          n.st  = LLACS_ST_TX;
        end
        LLACS_A_MAX_INFO_OCTETS: begin
          n.max_info_octets = (r.max_info_octets & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        end
        default: begin
        end
      endcase
    end

    // Frame processing, one cycle after the write
    case (r.st)
      LLACS_ST_RX: begin
        n.rxs          = '0;
        n.rxs.fmt      = d.fmt;
        n.rxs.is_cmd   = d.is_cmd;
        n.rxs.pf       = d.pf;
        n.rxs.ns       = d.fmt == LLACS_F_I ? d.ns : 7'h00;
        n.rxs.nr       = d.fmt == LLACS_F_U ? 7'h00 : d.nr;
        n.rxs.addr_ok  = addr_ok;
        n.rxs.group    = d.group;
        n.rxs.auto_rng = d.auto_rng;
        n.rxs.ucode    = d.ucode;
        n.rxs.undef    = d.undef;
        if (rx_live && !d.undef) begin
          if (d.fmt != LLACS_F_U) begin
            if (nr_ok) begin
              n.va = d.nr;
            end else begin
              n.rxs.nr_err = 1'b1;
            end
          end
          if (d.fmt == LLACS_F_I && d.ns == r.vr) begin
            n.vr         = 7'(r.vr + 7'h01);
            n.rxs.seq_ok = 1'b1;
          end
          if (d.fmt == LLACS_F_U && d.ucode == LLACS_U_SET_EXTENDED_BALANCED_MODE && d.is_cmd) begin
            n.vs        = 7'h00;
            n.va        = 7'h00;
            n.vr        = 7'h00;
            n.ua_due    = 1'b1;
            n.rxs.set_extended_balanced_mode = 1'b1;
          end
        end
        // Poll capture comes last so it wins over any clear
        if (addr_ok && d.is_cmd && d.pf) begin
          n.poll = 1'b1;
        end
        n.rxs.poll = n.poll;
      end
      LLACS_ST_TX: begin
        n.refused = 1'b0;
        case (tfmt)
          LLACS_F_I: begin
            if (r.cfg.unack || win_full) begin
              n.refused = 1'b1;
            end else begin
              n.txh = {r.vr, tf, r.vs, 1'b0, oa2, oa1};
              n.vs  = 7'(r.vs + 7'h01);
            end
          end
          LLACS_F_S: begin
            if (r.cfg.unack || tcode[1:0] == 2'h3) begin
              n.refused = 1'b1;
            end else begin
              n.txh = {r.vr, tf, 4'h0, tcode[1:0], 2'b01, oa2, oa1};
            end
          end
          LLACS_F_U: begin
            if (tcode == LLACS_U_NONE) begin
              n.refused = 1'b1;
            end else begin
              n.txh = {8'h00, ouc, oa2, oa1};
              if (tcode == LLACS_U_UA) begin
                n.ua_due = 1'b0;
              end
            end
          end
          default: begin
            n.refused = 1'b1;
          end
        endcase
        if (!n.refused && tresp) begin
          n.poll = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_rst_assign: begin
        r       <= '0;
        r.st    <= LLACS_ST_IDLE;
        r.cfg.k <= LLACS_K_RST;
        r.max_info_octets  <= LLACS_MAX_INFO_OCTETS_RST;
      end
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_vr_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_live && !d.undef && d.fmt == LLACS_F_I && d.ns == r.vr)
    |=> r.vr == 7'($past(r.vr) + 7'h01) && r.rxs.seq_ok)
    else $error("receive state did not step on in-sequence I frame");

  chk_va_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st != LLACS_ST_RX || (rx_live && !nr_ok && d.fmt != LLACS_F_U))
    |=> $stable(r.va))
    else $error("acknowledge state moved without a valid receive number");

  chk_win_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == LLACS_ST_TX && tfmt == LLACS_F_I && win_full)
    |=> $stable(r.vs) && r.refused)
    else $error("I frame sent with the window full");

  chk_set_extended_balanced_mode_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_live && d.fmt == LLACS_F_U && d.ucode == LLACS_U_SET_EXTENDED_BALANCED_MODE && d.is_cmd)
    |=> r.vs == 7'h00 && r.va == 7'h00 && r.vr == 7'h00 && r.ua_due)
    else $error("mode set did not clear the state variables");

  chk_tx_numbers: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == LLACS_ST_TX && tfmt == LLACS_F_I && !win_full && !r.cfg.unack)
    |=> r.txh[23:17] == $past(r.vs) && r.txh[31:25] == $past(r.vr))
    else $error("sent I frame numbers differ from state variables");

  chk_s_nr: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == LLACS_ST_TX && tfmt == LLACS_F_S && !r.cfg.unack && tcode[1:0] != 2'h3)
    |=> r.txh[31:25] == $past(r.vr) && r.txh[17:16] == 2'b01)
    else $error("sent S frame receive number wrong");

  chk_unack_still: assert property (@(posedge clk_i) disable iff (rst_i)
    r.cfg.unack |=> $stable(r.vs) && $stable(r.va) && $stable(r.vr))
    else $error("state variables moved in unacknowledged operation");

  chk_cr_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == LLACS_ST_TX && !tresp && tfmt == LLACS_F_U && tcode != LLACS_U_NONE)
    |=> r.txh[1] == $past(r.cfg.net) && r.txh[8])
    else $error("command C/R bit wrong for side");

  chk_final_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.st == LLACS_ST_TX && tresp && r.poll && tfmt == LLACS_F_U && tcode != LLACS_U_NONE)
    |=> r.txh[20] && !r.poll)
    else $error("poll answer sent without final bit");

endmodule : llacs_top
`default_nettype wire

// ### test/llacs_peer.sv
// Peer data link entity model: builds the headers that the far end sends
`timescale 1ns/10ps
`default_nettype none
module llacs_peer
  import llacs_pkg::*;
(
  // Frame request
  input  wire logic [1:0]  fmt_i,
  input  wire logic [2:0]  code_i,
  input  wire logic        cmd_i,
  input  wire logic        pf_i,
  input  wire logic [6:0]  ns_i,
  input  wire logic [6:0]  nr_i,
  // Addressing
  input  wire logic [5:0]  sap_i,
  input  wire logic [6:0]  tei_i,
  // Built header
  output var  logic [31:0] hdr_o
);
  // ----------------------------------------
  // Header build, peer sits on the network side
  // ----------------------------------------
  always_comb begin
    hdr_o[7:0]  = {sap_i, cmd_i, 1'h0};
    hdr_o[15:8] = {tei_i, 1'h1};
    case (fmt_i)
      LLACS_F_I: begin
        hdr_o[31:16] = {nr_i, pf_i, ns_i, 1'h0};
      end
      LLACS_F_S: begin
        hdr_o[31:16] = {nr_i, pf_i, 4'h0, code_i[1:0], 2'h1};
      end
      default: begin
        // Single control octet, so the top byte stays clear
        hdr_o[31:16] = {8'h00, LLACS_U_ENC[code_i] | {3'h0, pf_i, 4'h0}};
      end
    endcase
  end
endmodule : llacs_peer
`default_nettype wire

// ### test/tb_top.sv
// Testbench: register level scenarios of the link layer block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import llacs_pkg::*;
;
  localparam logic [31:0] ALL_M = 32'hffff_ffff;
  logic        clk_i    = 1'h0;
  logic        rst_i    = 1'h1;
  logic        wb_cyc   = 1'h0;
  logic        wb_stb   = 1'h0;
  logic        wb_we    = 1'h0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [31:0] wb_dat   = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [1:0]  p_fmt    = 2'h0;
  logic [2:0]  p_code   = 3'h0;
  logic        p_cmd    = 1'h0;
  logic        p_pf     = 1'h0;
  logic [6:0]  p_ns     = 7'h00;
  logic [6:0]  p_nr     = 7'h00;
  logic [6:0]  p_tei    = 7'h00;
  logic [31:0] p_hdr;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cycles    = 0;

  always #5 clk_i = ~clk_i;

  llacs_top u_dut (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc),
    .wb_stb_i (wb_stb),
    .wb_we_i  (wb_we),
    .wb_adr_i (wb_adr),
    .wb_sel_i (4'hf),
    .wb_dat_i (wb_dat),
    .wb_dat_o (wb_rdat),
    .wb_ack_o (wb_ack)
  );

  llacs_peer u_peer (
    .fmt_i  (p_fmt),
    .code_i (p_code),
    .cmd_i  (p_cmd),
    .pf_i   (p_pf),
    .ns_i   (p_ns),
    .nr_i   (p_nr),
    .sap_i  (6'h00),
    .tei_i  (p_tei),
    .hdr_o  (p_hdr)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: read %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: hold everything until ack is sampled, then release
  // Waits for ack without a local limit; the cycle guard below ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'h1);
    q = wb_rdat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0000_0000, q);
    check(q & m, e);
  endtask : rdm

  task automatic rx(input logic [1:0] f, input logic [2:0] c, input logic cm, input logic pf,
                    input logic [6:0] ns, input logic [6:0] nr, input logic [6:0] t);
    p_fmt  <= f;
    p_code <= c;
    p_cmd  <= cm;
    p_pf   <= pf;
    p_ns   <= ns;
    p_nr   <= nr;
    p_tei  <= t;
    @(posedge clk_i);
    wr(LLACS_A_RXH, p_hdr);
  endtask : rx

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdm(LLACS_A_CFG, ALL_M, 32'h0007_0000);
    rdm(LLACS_A_MAX_INFO_OCTETS, 32'h0000_ffff, 32'h0000_0100);
    rdm(LLACS_A_VAR, ALL_M, 32'h0000_0000);
    rdm(8'h1c, ALL_M, 32'h0000_0000);
    wr(LLACS_A_CFG, 32'h0007_0140);
    rdm(LLACS_A_CFG, ALL_M, 32'h0007_0140);
  endtask : t_reset

  task automatic t_window;
    for (int i = 0; i < 7; i++) begin
      wr(LLACS_A_TXC, 32'h0000_0000);
      rdm(LLACS_A_TXH, ALL_M, {8'h00, 7'(i), 1'h0, 16'h0b00});
    end
    // Eighth frame hits the window of seven and must leave the header alone
    wr(LLACS_A_TXC, 32'h0000_0000);
    rdm(LLACS_A_TXH, ALL_M, 32'h000c_0b00);
    rdm(LLACS_A_VAR, ALL_M, 32'h0300_0007);
  endtask : t_window

  task automatic t_rx;
    rx(LLACS_F_I, 3'h0, 1'h1, 1'h0, 7'h00, 7'h03, 7'h05);
    rdm(LLACS_A_RXS, 32'h0063_fff3, 32'h0040_1800);
    rdm(LLACS_A_VAR, 32'h017f_7f7f, 32'h0001_0307);
    rx(LLACS_F_I, 3'h0, 1'h1, 1'h0, 7'h05, 7'h03, 7'h05);
    rdm(LLACS_A_RXS, 32'h0063_fff3, 32'h0000_1850);
    rdm(LLACS_A_VAR, 32'h017f_7f7f, 32'h0001_0307);
    rx(LLACS_F_S, 3'h0, 1'h1, 1'h0, 7'h00, 7'h64, 7'h05);
    rdm(LLACS_A_RXS, 32'h0063_fff3, 32'h0023_2001);
    rdm(LLACS_A_VAR, 32'h017f_7f7f, 32'h0001_0307);
    for (int c = 0; c < 3; c++) begin
      rx(LLACS_F_S, 3'(c), 1'h0, 1'h0, 7'h00, 7'h07, 7'h05);
      rdm(LLACS_A_RXS, 32'h0063_fff7, 32'h0000_3801);
    end
    rdm(LLACS_A_VAR, 32'h017f_7f7f, 32'h0001_0707);
  endtask : t_rx

  task automatic t_addr;
    rx(LLACS_F_I, 3'h0, 1'h1, 1'h0, 7'h01, 7'h07, 7'h7f);
    rdm(LLACS_A_RXS, 32'h001c_0000, 32'h000c_0000);
    rx(LLACS_F_I, 3'h0, 1'h1, 1'h0, 7'h02, 7'h07, 7'h46);
    rdm(LLACS_A_RXS, 32'h001c_0000, 32'h0010_0000);
    rx(LLACS_F_I, 3'h0, 1'h1, 1'h0, 7'h02, 7'h07, 7'h3f);
    rdm(LLACS_A_RXS, 32'h001c_0000, 32'h0000_0000);
    rdm(LLACS_A_VAR, 32'h007f_0000, 32'h0002_0000);
  endtask : t_addr

  task automatic t_mode;
    rx(LLACS_F_U, LLACS_U_SET_EXTENDED_BALANCED_MODE, 1'h1, 1'h1, 7'h00, 7'h00, 7'h05);
    rdm(LLACS_A_RXS, ALL_M, 32'h1904_000f);
    rdm(LLACS_A_VAR, 32'h047f_7f7f, 32'h0400_0000);
    wr(LLACS_A_TXC, 32'h0000_0053);
    rdm(LLACS_A_TXH, ALL_M, 32'h0073_0b02);
    rdm(LLACS_A_VAR, 32'h0400_0000, 32'h0000_0000);
    for (int c = 0; c < 7; c++) begin
      wr(LLACS_A_TXC, 32'(4 * c + 3));
      rdm(LLACS_A_TXH, ALL_M, {8'h00, LLACS_U_ENC[c], 16'h0b00});
    end
  endtask : t_mode

  task automatic t_wrap;
    wr(LLACS_A_CFG, 32'h007f_0140);
    repeat (100) wr(LLACS_A_TXC, 32'h0000_0000);
    rx(LLACS_F_S, 3'h0, 1'h0, 1'h0, 7'h00, 7'h64, 7'h05);
    repeat (28) wr(LLACS_A_TXC, 32'h0000_0000);
    rdm(LLACS_A_TXH, ALL_M, 32'h00fe_0b00);
    rdm(LLACS_A_VAR, 32'h0000_7f7f, 32'h0000_6400);
    // Ack across the wrap: distance is taken modulo the sequence space
    rx(LLACS_F_S, 3'h0, 1'h0, 1'h0, 7'h00, 7'h00, 7'h05);
    rdm(LLACS_A_VAR, 32'h0000_7f7f, 32'h0000_0000);
  endtask : t_wrap

  task automatic t_unack;
    wr(LLACS_A_CFG, 32'h0007_4140);
    rx(LLACS_F_I, 3'h0, 1'h1, 1'h0, 7'h00, 7'h00, 7'h05);
    wr(LLACS_A_TXC, 32'h0000_0000);
    rdm(LLACS_A_VAR, 32'h027f_7f7f, 32'h0200_0000);
    wr(LLACS_A_MAX_INFO_OCTETS, 32'h0000_0104);
    rdm(LLACS_A_MAX_INFO_OCTETS, 32'h0000_ffff, 32'h0000_0104);
  endtask : t_unack

  // ----------------------------------------
  // Sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_window();
    t_rx();
    t_addr();
    t_mode();
    t_wrap();
    t_unack();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
